// file: udec_pkg.sv
package udec_pkg;
  // widths of the endpoint settings
  localparam int MPS_W = 11;
  localparam int DMA_W = 2;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  // reset values of the settings
  localparam logic [MPS_W-1:0] MPS_RESET = 11'h040;
  localparam logic [DMA_W-1:0] DMA_RESET = 2'h0;
  // endpoint status bit positions
  localparam int ST_W = 7;
  localparam int ST_PKT_READY = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_OUT_FULL = 2;
  localparam int ST_IN_NOT_EMPTY = 3;
  localparam int ST_UNDERRUN = 4;
  localparam int ST_IN_STALLED = 5;
  localparam int ST_OUT_STALLED = 6;
  localparam logic [ST_W-1:0] ST_RESET = 7'h00;
  // transfer types
  typedef enum logic [1:0] {
    ep_type_control,
    ep_type_isochronous,
    ep_type_bulk,
    ep_type_interrupt
  } udec_ep_kind_type;
  // transmit side states
  typedef enum logic {
    udec_tx_loading,
    udec_tx_pending
  } udec_tx_state_type;
endpackage

// file: udec_mem.sv
module udec_mem import udec_pkg::*; #(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic ref_clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port, data one cycle after the address
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] words [DEPTH];

  // write-first so a word written to the read address shows at once
  always_ff @(posedge ref_clk) begin
    if (we) begin
      words[waddr] <= wdata;
    end
    if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= words[raddr];
    end
  end
endmodule

// file: udec_fifo.sv
module udec_fifo import udec_pkg::*; #(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [AW:0] count
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } udec_fifo_state_type;

  udec_fifo_state_type s;
  udec_fifo_state_type next_s;
  logic push;
  logic pop;

  // refuse a depth the pointers cannot wrap over
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("fifo depth must be a power of two");
  end

  // handshakes and level
  assign in_ready = s.cnt != (AW + 1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign count = s.cnt;

  // pointer update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  udec_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .ref_clk(ref_clk),
    .we(push),
    .waddr(s.wr),
    .wdata(in_data),
    .raddr(next_s.rd),
    .rdata(out_data)
  );
endmodule

// file: udec_endpoint.sv
// Summary of operation
// - endpoint zero keeps a fixed type and packet size, but its DMA mode follows configuration writes; other endpoints take configuration writes
// - each configurable endpoint stores one of four transfer types
// - each configurable endpoint stores its maximum packet size
// - each endpoint stores a DMA access mode
// - auto transmit starts sending once a full maximum packet is loaded
// - auto request asks for data once no packet is held and room for a maximum packet exists
// - auto clear drops packet ready after the last byte is read
// - software acknowledges read data; endpoint zero also marks the last packet
// - last packet mark is ignored on endpoints other than zero
// - stall is set on the IN or OUT half as selected
// - status clear clears the status bits set in the mask, except out full and IN not empty, which follow the FIFO levels
// - a command switches the controller into device mode
// - the received byte count in the FIFO is reported
// - a zero length packet is a valid packet with count zero
// - a read fails only when no received packet is present
// - loading while a packet is pending stores nothing and reports busy
// - without auto transmit, sending starts only on a start command
module udec_endpoint import udec_pkg::*; #(
  parameter int EP_NUM = 1,
  parameter int DEPTH = FIFO_DEPTH,
  parameter logic [MPS_W-1:0] EP0_MPS = MPS_RESET
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // mode command
  input wire logic dev_mode_cmd,
  output logic dev_mode,
  // configuration write
  input wire logic cfg_write,
  input wire logic dir_select_in,
  input wire udec_ep_kind_type cfg_type,
  input wire logic [MPS_W-1:0] cfg_max_packet_bytes,
  input wire logic [DMA_W-1:0] cfg_dma_mode,
  input wire logic cfg_auto_transmit,
  input wire logic cfg_auto_request,
  input wire logic cfg_auto_clear,
  // configuration read back
  output udec_ep_kind_type ep_type,
  output logic [MPS_W-1:0] max_packet_bytes,
  output logic [DMA_W-1:0] ep_dma_access_mode,
  output logic auto_transmit_on_full_packet,
  output logic auto_request_on_drain,
  output logic auto_clear_packet_ready,
  // stall, acknowledge, status clear
  input wire logic stall_cmd,
  input wire logic stall_dir_in,
  input wire logic ack_cmd,
  input wire logic last_packet_indication,
  input wire logic status_clear,
  input wire logic [ST_W-1:0] status_clear_mask,
  output logic [ST_W-1:0] status,
  output logic stall_in,
  output logic stall_out,
  output logic data_end,
  // software load of the IN FIFO
  input wire logic put_valid,
  input wire logic [DATA_W-1:0] put_data,
  output logic put_ready,
  output logic put_busy,
  input wire logic send_cmd,
  // software read of the OUT FIFO
  input wire logic get_req,
  output logic get_fail,
  output logic get_valid,
  input wire logic get_ready,
  output logic [DATA_W-1:0] get_data,
  output logic [$clog2(DEPTH):0] rx_byte_count,
  // bus side, IN direction
  input wire logic link_in_token,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  output logic [DATA_W-1:0] link_tx_data,
  input wire logic link_tx_done,
  // bus side, OUT direction
  input wire logic link_rx_valid,
  output logic link_rx_ready,
  input wire logic [DATA_W-1:0] link_rx_data,
  input wire logic link_rx_end,
  output logic out_request
);
  localparam int CW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic dev_mode;
    udec_ep_kind_type ep_type;
    logic [MPS_W-1:0] mps;
    logic [DMA_W-1:0] dma;
    logic auto_tx;
    logic auto_req;
    logic auto_clr;
    udec_tx_state_type tx;
    logic [ST_W-1:0] st;
    logic stall_in;
    logic stall_out;
    logic data_end;
    logic room_prev;
    logic out_request;
  } udec_state_type;

  udec_state_type s;
  udec_state_type next_s;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic tx_in_ready;
  logic tx_out_valid;
  logic [CW-1:0] tx_count;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [CW-1:0] rx_count;
  logic rx_push;
  logic rx_pop;
  logic room;

  // refuse settings the logic cannot serve
  if (EP_NUM < 0 || EP_NUM > 15 || DEPTH < 2) begin
    $error("endpoint number or fifo depth out of range");
  end

  // widen a fifo level for compare with the packet size
  function automatic logic [MPS_W-1:0] lvl(input logic [CW-1:0] c);
    lvl = MPS_W'(c);
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // software load path, refused while a packet waits
  assign put_ready = s.tx == udec_tx_loading && tx_in_ready;
  assign put_busy = put_valid && s.tx == udec_tx_pending;
  assign link_tx_valid = s.tx == udec_tx_pending && tx_out_valid;

  // receive path holds one packet at a time
  assign link_rx_ready = !s.st[ST_PKT_READY] && rx_in_ready;
  assign rx_push = link_rx_valid && link_rx_ready;
  assign get_valid = s.st[ST_PKT_READY] && rx_out_valid;
  assign rx_pop = get_valid && get_ready;
  assign get_fail = get_req && !s.st[ST_PKT_READY];
  assign rx_byte_count = rx_count;
  assign room = lvl(CW'(DEPTH) - rx_count) >= s.mps;

  // next state of the endpoint
  always_comb begin
    next_s = s;
    next_s.out_request = 1'b0;
    if (dev_mode_cmd) begin
      next_s.dev_mode = 1'b1;
    end
    if (cfg_write && EP_NUM != 0) begin
      next_s.ep_type = cfg_type;
      next_s.mps = cfg_max_packet_bytes;
      if (dir_select_in) begin
        next_s.auto_tx = cfg_auto_transmit;
      end else begin
        next_s.auto_req = cfg_auto_request;
        next_s.auto_clr = cfg_auto_clear;
      end
    end
    if (cfg_write) begin
      next_s.dma = cfg_dma_mode;
    end
    // transmit state
    unique case (s.tx)
      udec_tx_loading: begin
        if (send_cmd) begin
          next_s.tx = udec_tx_pending;
        end else if (s.auto_tx && lvl(tx_count) >= s.mps && s.mps != '0) begin
          next_s.tx = udec_tx_pending;
        end
      end
      udec_tx_pending: begin
        if (link_tx_done) begin
          next_s.tx = udec_tx_loading;
        end
      end
    endcase
    // stall halves
    if (stall_cmd && stall_dir_in) begin
      next_s.stall_in = 1'b1;
    end
    if (stall_cmd && !stall_dir_in) begin
      next_s.stall_out = 1'b1;
    end
    // acknowledge, last mark kept on endpoint zero only
    next_s.data_end = 1'b0;
    if (ack_cmd) begin
      next_s.st[ST_PKT_READY] = 1'b0;
      next_s.data_end = EP_NUM == 0 && last_packet_indication;
    end
    // software clear first so that events set later win
    if (status_clear) begin
      next_s.st = next_s.st & ~status_clear_mask;
    end
    if (status_clear && status_clear_mask[ST_IN_STALLED]) begin
      next_s.stall_in = 1'b0;
    end
    if (status_clear && status_clear_mask[ST_OUT_STALLED]) begin
      next_s.stall_out = 1'b0;
    end
    if (s.auto_clr && rx_pop && rx_count == CW'(1)) begin
      next_s.st[ST_PKT_READY] = 1'b0;
    end
    // bus events
    if (link_rx_end && !s.st[ST_PKT_READY]) begin
      next_s.st[ST_PKT_READY] = 1'b1;
    end
    if (link_rx_valid && !link_rx_ready) begin
      next_s.st[ST_OVERRUN] = 1'b1;
    end
    if (link_in_token && s.stall_in) begin
      next_s.st[ST_IN_STALLED] = 1'b1;
    end
    if (link_rx_valid && s.stall_out) begin
      next_s.st[ST_OUT_STALLED] = 1'b1;
    end
    if (link_in_token && !s.stall_in && s.tx == udec_tx_loading) begin
      next_s.st[ST_UNDERRUN] = 1'b1;
    end
    next_s.st[ST_OUT_FULL] = !rx_in_ready;
    next_s.st[ST_IN_NOT_EMPTY] = tx_count != '0;
    // request on the rising edge of free room
    next_s.room_prev = s.auto_req && !s.st[ST_PKT_READY] && room;
    if (next_s.room_prev && !s.room_prev) begin
      next_s.out_request = 1'b1;
    end
  end

  // state register with fixed endpoint zero settings
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ep_type <= ep_type_control;
      s.mps <= EP_NUM == 0 ? EP0_MPS : MPS_RESET;
      s.dma <= DMA_RESET;
      s.st <= ST_RESET;
      s.tx <= udec_tx_loading;
    end else begin
      s <= next_s;
    end
  end

  // outputs from the state register
  assign dev_mode = s.dev_mode;
  assign ep_type = s.ep_type;
  assign max_packet_bytes = s.mps;
  assign ep_dma_access_mode = s.dma;
  assign auto_transmit_on_full_packet = s.auto_tx;
  assign auto_request_on_drain = s.auto_req;
  assign auto_clear_packet_ready = s.auto_clr;
  assign status = s.st;
  assign stall_in = s.stall_in;
  assign stall_out = s.stall_out;
  assign data_end = s.data_end;
  assign out_request = s.out_request;

  udec_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(put_valid && put_ready),
    .in_ready(tx_in_ready),
    .in_data(put_data),
    .out_valid(tx_out_valid),
    .out_ready(link_tx_ready && s.tx == udec_tx_pending),
    .out_data(link_tx_data),
    .count(tx_count)
  );

  udec_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(link_rx_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(get_data),
    .count(rx_count)
  );

  // steps of a transmit
  sequence seq_send_cmd;
    s.tx == udec_tx_loading && send_cmd;
  endsequence
  sequence seq_pending;
    s.tx == udec_tx_pending;
  endsequence

  a_ep0_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    EP_NUM == 0 |-> s.mps == EP0_MPS && s.ep_type == ep_type_control)
    else $error("endpoint zero settings changed");
  a_cfg_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_write && EP_NUM != 0 |=> max_packet_bytes == $past(cfg_max_packet_bytes))
    else $error("packet size not stored");
  a_send_starts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_send_cmd |=> seq_pending)
    else $error("send command did not start transmit");
  a_auto_send: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s.tx == udec_tx_pending && !$past(s.tx == udec_tx_pending)
    |-> $past(send_cmd) || $past(s.auto_tx && lvl(tx_count) >= s.mps))
    else $error("transmit started without cause");
  a_busy_refuse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_pending |-> !put_ready && (put_valid == put_busy))
    else $error("load accepted while pending");
  a_done_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_pending ##0 link_tx_done |=> s.tx == udec_tx_loading)
    else $error("pending not cleared");
  a_read_fail: assert property (@(posedge ref_clk) disable iff (!rst_n)
    get_fail |-> !s.st[ST_PKT_READY] && !get_valid)
    else $error("read failed with packet present");
  a_last_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_end |-> EP_NUM == 0 && $past(ack_cmd && last_packet_indication))
    else $error("last mark on wrong endpoint");
  a_stall_half: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stall_cmd && !status_clear |=> (stall_in || !$past(stall_dir_in))
    && (stall_out || $past(stall_dir_in)))
    else $error("stall not set on chosen half");
  a_mask_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_clear && !link_rx_valid && !link_in_token && !link_rx_end
    |=> (status & $past(status_clear_mask) & 7'h73) == '0)
    else $error("masked status bit survived clear");
  a_zero_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    link_rx_end && !status[ST_PKT_READY] |=> status[ST_PKT_READY])
    else $error("packet end not flagged");
  a_dev_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_mode_cmd |=> dev_mode [*2])
    else $error("device mode not entered");
endmodule

// file: udec_host_model.sv
module udec_host_model import udec_pkg::*; (
  // clock
  input wire logic ref_clk,
  // IN direction
  output logic link_in_token,
  input wire logic link_tx_valid,
  output logic link_tx_ready,
  input wire logic [DATA_W-1:0] link_tx_data,
  output logic link_tx_done,
  // OUT direction
  output logic link_rx_valid,
  input wire logic link_rx_ready,
  output logic [DATA_W-1:0] link_rx_data,
  output logic link_rx_end
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] rq[$];
  logic [DATA_W-1:0] tq[$];
  logic slow;
  int hang;
  // idle bus
  initial begin
    {link_in_token, link_tx_ready, link_tx_done, link_rx_valid, link_rx_end, slow} = '0;
    link_rx_data = 8'hA5;
    hang = 0;
  end
  // one OUT packet from rq, each byte held until taken
  task automatic send_pkt();
    int k;
    for (k = 0; k < 100 && rq.size() > 0; k++) begin
      link_rx_valid = 1'b1;
      link_rx_data = rq[0];
      @(negedge ref_clk);
      if (link_rx_ready === 1'b1) void'(rq.pop_front()); // settled before the taking edge
      @(posedge ref_clk);
      #1;
    end
    if (rq.size() > 0) hang++;
    link_rx_valid = 1'b0;
    link_rx_data = ~link_rx_data; // released line stops showing the byte
    link_rx_end = 1'b1;
    @(posedge ref_clk);
    #1;
    link_rx_end = 1'b0;
  endtask
  // token, then collect n bytes, stalling at random when slow
  task automatic take_pkt(input int n);
    int k;
    link_in_token = 1'b1;
    @(posedge ref_clk);
    #1;
    link_in_token = 1'b0;
    for (k = 0; k < 200 && tq.size() < n; k++) begin
      link_tx_ready = slow ? 1'($urandom) : 1'b1;
      @(negedge ref_clk);
      if (link_tx_valid === 1'b1 && link_tx_ready) tq.push_back(link_tx_data);
      @(posedge ref_clk);
      #1;
    end
    if (tq.size() < n) hang++;
    link_tx_ready = 1'b0;
    link_tx_done = 1'b1;
    @(posedge ref_clk);
    #1;
    link_tx_done = 1'b0;
  endtask
endmodule

// file: testbench.sv
module testbench import udec_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, dev_mode_cmd, dev_mode, cfg_write, dir_select_in;
  udec_ep_kind_type cfg_type, ep_type;
  logic [MPS_W-1:0] cfg_max_packet_bytes, max_packet_bytes;
  logic [DMA_W-1:0] cfg_dma_mode, ep_dma_access_mode;
  logic cfg_auto_transmit, cfg_auto_request, cfg_auto_clear;
  logic auto_transmit_on_full_packet, auto_request_on_drain, auto_clear_packet_ready;
  logic stall_cmd, stall_dir_in, ack_cmd, last_packet_indication, status_clear;
  logic [ST_W-1:0] status_clear_mask, status;
  logic stall_in, stall_out, data_end, put_valid, put_ready, put_busy, send_cmd;
  logic get_req, get_fail, get_valid, get_ready, link_in_token, link_tx_valid;
  logic link_tx_ready, link_tx_done, link_rx_valid, link_rx_ready, link_rx_end;
  logic out_request;
  logic [DATA_W-1:0] put_data, get_data, link_tx_data, link_rx_data;
  logic [4:0] rx_byte_count;
  logic m_at, m_ar, m_ac;
  udec_ep_kind_type e0_type;
  logic [MPS_W-1:0] e0_mps;
  logic [DMA_W-1:0] e0_dma;
  logic e0_end;
  logic [7:0] exp_in[$];
  logic [7:0] exp_out[$];
  int n_fail, num_checks, i;

  udec_endpoint #(.EP_NUM(1)) uut (.ref_clk, .rstn, .dev_mode_cmd, .dev_mode, .cfg_write,
    .dir_select_in, .cfg_type, .cfg_max_packet_bytes, .cfg_dma_mode, .cfg_auto_transmit,
    .cfg_auto_request, .cfg_auto_clear, .ep_type, .max_packet_bytes, .ep_dma_access_mode,
    .auto_transmit_on_full_packet, .auto_request_on_drain, .auto_clear_packet_ready,
    .stall_cmd, .stall_dir_in, .ack_cmd, .last_packet_indication, .status_clear,
    .status_clear_mask, .status, .stall_in, .stall_out, .data_end, .put_valid, .put_data,
    .put_ready, .put_busy, .send_cmd, .get_req, .get_fail, .get_valid, .get_ready,
    .get_data, .rx_byte_count, .link_in_token, .link_tx_valid, .link_tx_ready,
    .link_tx_data, .link_tx_done, .link_rx_valid, .link_rx_ready, .link_rx_data,
    .link_rx_end, .out_request);
  // endpoint zero copy, its type and packet size must not follow configuration writes, its DMA mode must
  udec_endpoint #(.EP_NUM(0)) uut0 (.ref_clk, .rstn, .dev_mode_cmd, .dev_mode(),
    .cfg_write, .dir_select_in, .cfg_type, .cfg_max_packet_bytes, .cfg_dma_mode,
    .cfg_auto_transmit, .cfg_auto_request, .cfg_auto_clear, .ep_type(e0_type),
    .max_packet_bytes(e0_mps), .ep_dma_access_mode(e0_dma), .auto_transmit_on_full_packet(),
    .auto_request_on_drain(), .auto_clear_packet_ready(), .stall_cmd, .stall_dir_in,
    .ack_cmd, .last_packet_indication, .status_clear, .status_clear_mask, .status(),
    .stall_in(), .stall_out(), .data_end(e0_end), .put_valid, .put_data, .put_ready(),
    .put_busy(), .send_cmd, .get_req, .get_fail(), .get_valid(), .get_ready, .get_data(),
    .rx_byte_count(), .link_in_token, .link_tx_valid(), .link_tx_ready, .link_tx_data(),
    .link_tx_done, .link_rx_valid, .link_rx_ready(), .link_rx_data, .link_rx_end,
    .out_request());
  udec_host_model host (.ref_clk, .link_in_token, .link_tx_valid, .link_tx_ready,
    .link_tx_data, .link_tx_done, .link_rx_valid, .link_rx_ready, .link_rx_data,
    .link_rx_end);

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // shared helpers
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    n_fail += host.hang;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      $display("CHECK FAILED wait expected done seen timeout");
      give_verdict();
    end
  endtask
  task automatic pulse(ref logic s);
    tick(); // idle cycle keeps back to back strobes apart
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic cfg(input logic din, input int t, input int m, input logic x, input logic y);
    dir_select_in = din;
    cfg_type = udec_ep_kind_type'(t);
    cfg_max_packet_bytes = MPS_W'(m);
    cfg_dma_mode = DMA_W'($urandom);
    {cfg_auto_transmit, cfg_auto_request, cfg_auto_clear} = {x, x, y};
    if (din) m_at = x;
    else {m_ar, m_ac} = {x, y};
    pulse(cfg_write);
    chk("type", 16'(t), 16'(ep_type));
    chk("mps", 16'(m), 16'(max_packet_bytes));
    chk("dma", 16'(cfg_dma_mode), 16'(ep_dma_access_mode));
    chk("auto_tx", 16'(m_at), 16'(auto_transmit_on_full_packet));
    chk("auto_rq", 16'(m_ar), 16'(auto_request_on_drain));
    chk("auto_cl", 16'(m_ac), 16'(auto_clear_packet_ready));
    chk("e0_type", 16'(ep_type_control), 16'(e0_type));
    chk("e0_mps", 16'(MPS_RESET), 16'(e0_mps));
    chk("e0_dma", 16'(cfg_dma_mode), 16'(e0_dma));
  endtask
  task automatic put_bytes(input int n);
    int k;
    put_valid = 1'b1;
    for (int j = 0; j < n; j++) begin
      put_data = 8'($urandom);
      for (k = 0; k < 20 && put_ready !== 1'b1; k++) tick();
      guard(k, 20);
      exp_in.push_back(put_data);
      tick();
    end
    put_valid = 1'b0;
  endtask
  task automatic cmp_in();
    chk("tx_count", 16'(exp_in.size()), 16'(host.tq.size()));
    while (exp_in.size() > 0 && host.tq.size() > 0)
      chk("tx_data", 16'(exp_in.pop_front()), 16'(host.tq.pop_front()));
    exp_in.delete();
  endtask
  task automatic out_pkt(input int n);
    for (int j = 0; j < n; j++) begin
      exp_out.push_back(8'($urandom));
      host.rq.push_back(exp_out[j]);
    end
    host.send_pkt();
    tick();
    chk("pkt_ready", 16'h0001, 16'(status[ST_PKT_READY]));
    chk("rx_count", 16'(n), 16'(rx_byte_count));
  endtask
  task automatic get_pkt();
    int k;
    get_ready = 1'b1;
    for (k = 0; k < 100 && exp_out.size() > 0; k++) begin
      @(negedge ref_clk);
      if (get_valid === 1'b1) chk("get_data", 16'(exp_out.pop_front()), 16'(get_data));
      @(posedge ref_clk);
      #1;
    end
    guard(k, 100);
    get_ready = 1'b0;
    repeat (2) tick();
  endtask
  task automatic try_get(input logic e);
    get_req = 1'b1;
    #1;
    chk("get_fail", 16'(e), 16'(get_fail));
    tick();
    get_req = 1'b0;
  endtask

  // main sequence
  initial begin
    void'($urandom(43));
    {rstn, dev_mode_cmd, cfg_write, dir_select_in, cfg_auto_transmit} = '0;
    {cfg_auto_request, cfg_auto_clear, stall_cmd, stall_dir_in, ack_cmd} = '0;
    {last_packet_indication, status_clear, put_valid, send_cmd, get_req, get_ready} = '0;
    {m_at, m_ar, m_ac, cfg_max_packet_bytes, cfg_dma_mode, status_clear_mask} = '0;
    {put_data, n_fail, num_checks} = '0;
    cfg_type = ep_type_control;
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    repeat (3) tick();
    chk("rst_type", 16'(ep_type_control), 16'(ep_type));
    chk("rst_mps", 16'(MPS_RESET), 16'(max_packet_bytes));
    chk("rst_status", 16'(ST_RESET), 16'(status));
    pulse(dev_mode_cmd);
    chk("dev_mode", 16'h0001, 16'(dev_mode));
    for (i = 0; i < 4; i++) cfg(i[0], i, $urandom_range(1, 2047), 1'($urandom), 1'b0);
    // manual send: fill to refusal, send, busy while pending
    cfg(1'b1, 2, 2, 1'b0, 1'b0);
    put_bytes(FIFO_DEPTH);
    chk("tx_idle", 16'h0000, 16'(link_tx_valid));
    tick();
    put_valid = 1'b1;
    #1;
    chk("full_ready", 16'h0000, 16'(put_ready));
    tick();
    put_valid = 1'b0;
    pulse(send_cmd);
    put_valid = 1'b1;
    #1;
    chk("busy", 16'h0001, 16'(put_busy));
    chk("busy_ready", 16'h0000, 16'(put_ready));
    tick();
    put_valid = 1'b0;
    host.slow = 1'b1;
    host.take_pkt(FIFO_DEPTH);
    tick();
    cmp_in();
    chk("in_empty", 16'h0000, 16'(status[ST_IN_NOT_EMPTY]));
    chk("ready_back", 16'h0001, 16'(put_ready));
    // automatic send on a full packet
    cfg(1'b1, 3, 4, 1'b1, 1'b0);
    put_bytes(4);
    host.slow = 1'b0;
    host.take_pkt(4);
    cmp_in();
    // OUT read, no auto clear, acknowledge
    cfg(1'b0, 2, 4, 1'b0, 1'b0);
    try_get(1'b1);
    out_pkt(5);
    try_get(1'b0);
    get_pkt();
    chk("held_ready", 16'h0001, 16'(status[ST_PKT_READY]));
    last_packet_indication = 1'b1;
    pulse(ack_cmd);
    chk("data_end", 16'h0000, 16'(data_end));
    chk("e0_end", 16'h0001, 16'(e0_end));
    chk("ack_clear", 16'h0000, 16'(status[ST_PKT_READY]));
    // zero length packet and masked clear
    out_pkt(0);
    try_get(1'b0);
    chk("zlp_valid", 16'h0000, 16'(get_valid));
    status_clear_mask = 7'h7E;
    pulse(status_clear);
    chk("mask_keep", 16'h0001, 16'(status[ST_PKT_READY]));
    status_clear_mask = 7'h01;
    pulse(status_clear);
    chk("mask_clear", 16'h0000, 16'(status[ST_PKT_READY]));
    // auto clear and auto request after draining
    cfg(1'b0, 2, 4, 1'b1, 1'b1);
    out_pkt(3);
    chk("req_idle", 16'h0000, 16'(out_request));
    get_ready = 1'b1;
    for (i = 0; i < 20 && out_request !== 1'b1; i++) begin
      if (exp_out.size() > 0 && get_valid === 1'b1)
        chk("get_data", 16'(exp_out.pop_front()), 16'(get_data));
      tick();
    end
    guard(i, 20);
    get_ready = 1'b0;
    chk("auto_clear", 16'h0000, 16'(status[ST_PKT_READY]));
    // stall each half
    stall_dir_in = 1'b1;
    pulse(stall_cmd);
    chk("stall_in", 16'h0001, 16'(stall_in));
    chk("stall_out0", 16'h0000, 16'(stall_out));
    stall_dir_in = 1'b0;
    pulse(stall_cmd);
    chk("stall_out", 16'h0001, 16'(stall_out));
    give_verdict();
  end
endmodule
